// ### testbench.sv
// Self-checking bench for the time proportioning output block
`timescale 1ns/1ps
module testbench;
   import tpo_pkg::*;
   localparam int unsigned TC = 4;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic [CTRL_WIDTH-1:0] word = 12'h000;
   logic on_out, pe;
   logic [CNT_WIDTH:0] duty;
   logic [15:0] on_cyc;
   int n_fail = 0;
   int cmp_count = 0;
   tpo_top #(.TICK_CYC(TC), .PER_TICKS(1000)) uut (.i_clock(i_clock),
      .i_rst(i_rst), .i_control_output_word(word),
      .o_on_off_output(on_out), .o_period_end(pe), .o_duty_count(duty));
   tpo_actuator_model act (.i_clock(i_clock), .i_rst(i_rst),
      .i_drive(on_out), .i_period_end(pe), .o_on_cycles(on_cyc));
   initial begin
      forever #20 i_clock = ~i_clock;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_pe(output int n);
      n = 0;
      do begin
         @(negedge i_clock);
         n++;
      end while (pe !== 1'b1 && n < 5000);
      chk({15'h0000, pe}, 16'h0001);
   endtask
   // Capture, hold through a changed word, then total the on-time
   task automatic run_duty(input logic [11:0] w, input logic [10:0] d);
      int diff;
      int n;
      word = w;
      wait_pe(n);
      @(negedge i_clock);
      chk({5'h00, duty}, {5'h00, d});
      chk({15'h0000, on_out}, 16'h0000);
      word = ~w;
      wait_pe(n);
      chk(16'(n), 16'(TC * 1000 - 1));
      chk({5'h00, duty}, {5'h00, d});
      diff = int'(on_cyc) - int'(d) * TC;
      chk({15'h0000, (diff >= -2 && diff <= 0)}, 16'h0001);
      $display("Test word %h duty %0d done", w, d);
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge i_clock);
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (3) @(negedge i_clock);
      i_rst = 1'b0;
      chk({4'h0, on_out, duty}, 16'h0000);
      $display("Test reset done");
      run_duty(12'hfff, 11'h3e8);
      run_duty(12'h000, 11'h000);
      run_duty(12'h800, 11'h1f4);
      run_duty(12'h001, 11'h000);
      run_duty(12'h005, 11'h001);
      wrap_up();
   end
endmodule

// ### tpo_actuator_model.sv
// Behavioural on/off actuator that totals its energized clock cycles
`timescale 1ns/1ps
module tpo_actuator_model (
   input wire logic i_clock,        // System clock
   input wire logic i_rst,          // Sync reset
   input wire logic i_drive,        // Actuator drive
   input wire logic i_period_end,   // Period boundary
   output logic [15:0] o_on_cycles  // Energized cycles this period
);
   // Restart the tally at each boundary so one period is seen, less its boundary cycle
   always_ff @(posedge i_clock) begin
      if (i_rst || i_period_end) begin
         o_on_cycles <= 16'h0000;
      end else begin
         o_on_cycles <= o_on_cycles + {15'h0000, i_drive};
      end
   end
endmodule

// ### tpo_period_gen.sv
// Tick prescaler and self-restarting period timer
`timescale 1ns/1ps
module tpo_period_gen import tpo_pkg::*; #(
   parameter int unsigned TICK_CYC = TICK_CYCLES,  // Clocks per tick
   parameter int unsigned PER_TICKS = PERIOD_TICKS // Ticks per period
) (
   input wire logic i_clock,    // System clock
   input wire logic i_rst,      // Synchronous reset
   tpo_tick_if.gen tk           // Tick and boundary out
);
   logic [31:0] pre_r;
   logic [CNT_WIDTH-1:0] period_timer_r;
   wire pre_wrap = (pre_r == 32'(TICK_CYC - 1));
   wire per_done = (period_timer_r == CNT_WIDTH'(PER_TICKS - 1));

   assign tk.tick = pre_wrap;
   assign tk.period_end = pre_wrap && per_done;

   always_ff @(posedge i_clock) begin
      if (i_rst || pre_wrap) begin
         pre_r <= 32'h0;
      end else begin
         pre_r <= pre_r + 32'h1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst || tk.period_end) begin
         period_timer_r <= CNT_RESET;
      end else if (pre_wrap) begin
         period_timer_r <= period_timer_r + CNT_WIDTH'(1);
      end
   end

   period_wrap_a: assert property (@(posedge i_clock)
      disable iff (i_rst) tk.period_end |=> period_timer_r == CNT_RESET)
      else $error("period timer did not restart");
endmodule

// ### tpo_pkg.sv
// Constants for the time proportioning output block
package tpo_pkg;
   localparam int unsigned CLOCK_HZ = 25000000;
   localparam int unsigned TICK_MS = 10;
   localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
   localparam int unsigned PERIOD_TICKS = 1000;
   localparam int unsigned CTRL_WIDTH = 12;
   localparam int unsigned CTRL_MAX = 4095;
   localparam int unsigned CNT_WIDTH = 10;
   localparam logic [CNT_WIDTH-1:0] CNT_RESET = 10'h000;
   localparam logic [CNT_WIDTH:0] DUTY_RESET = 11'h000;
endpackage

// ### tpo_tick_if.sv
// Tick and period-boundary signals shared between the timer modules
`timescale 1ns/1ps
interface tpo_tick_if;
   logic tick;
   logic period_end;
   modport gen (output tick, output period_end);
   modport use_side (input tick, input period_end);
endinterface

// ### tpo_top.sv
// Time proportioning on/off output driven by a loop control word
//
// How it works
// - Period timer counts 0.01 s ticks to 1000, restarting itself.
// - Period end pulses one cycle and clears both timers.
// - Control output word is captured at each period end.
// - Captured value divided by 4.095, mapping 0-4095 onto 0-1000.
// - Duty timer counts ticks to the duty count, then output drops.
// - Output is high from period start until the duty timer expires.
// - Output held off during the clearing cycle at period end.
// - One duty count equals one period tick, 1 part in 1000.
`timescale 1ns/1ps
module tpo_top import tpo_pkg::*; #(
   parameter int unsigned TICK_CYC = TICK_CYCLES,  // Clocks per tick
   parameter int unsigned PER_TICKS = PERIOD_TICKS // Ticks per period
) (
   input wire logic i_clock,                              // 25 MHz clock
   input wire logic i_rst,                                // Sync reset
   input wire logic [CTRL_WIDTH-1:0] i_control_output_word, // Loop output
   output logic o_on_off_output,                          // Actuator drive
   output logic o_period_end,                             // Boundary pulse
   output logic [CNT_WIDTH:0] o_duty_count                // Held duty
);
   tpo_tick_if tk ();
   logic [CNT_WIDTH:0] duty_r;
   logic [CNT_WIDTH:0] duty_nxt;
   logic [CNT_WIDTH:0] duty_timer_r;
   logic on_r;
   logic on_nxt;

   tpo_period_gen #(.TICK_CYC(TICK_CYC), .PER_TICKS(PER_TICKS)) u_gen (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .tk(tk)
   );

   // Rounded scaling x*1000/4095, result 0..1000
   function automatic logic [CNT_WIDTH:0] scale(input logic [11:0] x);
      logic [23:0] p;
      p = 24'(x) * 24'd1000 + 24'd2047;
      return (CNT_WIDTH+1)'(p / 24'(CTRL_MAX));
   endfunction

   assign duty_nxt = tk.period_end ? scale(i_control_output_word) : duty_r;
   wire duty_done = (duty_timer_r >= duty_r);
   // high until expiry, off in clearing cycle
   assign on_nxt = !tk.period_end && !duty_done;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         duty_r <= DUTY_RESET;
      end else begin
         duty_r <= duty_nxt;
      end
   end

   // duty timer, cleared at period end, same tick
   always_ff @(posedge i_clock) begin
      if (i_rst || tk.period_end) begin
         duty_timer_r <= DUTY_RESET;
      end else if (tk.tick && !duty_done) begin
         duty_timer_r <= duty_timer_r + (CNT_WIDTH+1)'(1);
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         on_r <= 1'b0;
      end else begin
         on_r <= on_nxt;
      end
   end

   assign o_on_off_output = on_r;
   assign o_period_end = tk.period_end;
   assign o_duty_count = duty_r;

   // Helper cycle counter for the period length check
   logic [31:0] gap_r;
   logic seen_r;
   always_ff @(posedge i_clock) begin
      if (i_rst || tk.period_end) begin
         gap_r <= 32'h1;
      end else begin
         gap_r <= gap_r + 32'h1;
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         seen_r <= 1'b0;
      end else if (tk.period_end) begin
         seen_r <= 1'b1;
      end
   end

   sequence boundary_s;
      tk.period_end;
   endsequence

   sequence cleared_s;
      duty_timer_r == DUTY_RESET && !o_on_off_output;
   endsequence

   period_len_a: assert property (@(posedge i_clock) disable iff (i_rst)
      tk.period_end && seen_r |-> gap_r == 32'(TICK_CYC * PER_TICKS))
      else $error("period length wrong");

   end_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
      boundary_s |=> !tk.period_end)
      else $error("period end longer than one cycle");

   clear_both_a: assert property (@(posedge i_clock) disable iff (i_rst)
      boundary_s |=> cleared_s)
      else $error("timers not cleared or output on at boundary");

   capture_val_a: assert property (@(posedge i_clock) disable iff (i_rst)
      boundary_s |=> duty_r == scale($past(i_control_output_word)))
      else $error("duty count not captured");

   scale_range_a: assert property (@(posedge i_clock) disable iff (i_rst)
      duty_r <= (CNT_WIDTH+1)'(PER_TICKS))
      else $error("duty count above period");

   duty_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !tk.period_end |=> $stable(duty_r))
      else $error("duty count changed mid period");

   duty_stop_a: assert property (@(posedge i_clock) disable iff (i_rst)
      duty_timer_r >= duty_r |=> !o_on_off_output)
      else $error("output on after duty expiry");

   on_while_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !tk.period_end && duty_timer_r < duty_r |=> o_on_off_output)
      else $error("output off before duty expiry");

   tick_step_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !tk.period_end && !tk.tick |=> $stable(duty_timer_r))
      else $error("duty timer moved without a tick");

   // Registered copy of the boundary, high in the first cycle of a period
   logic after_end_r;
   localparam logic [CNT_WIDTH:0] FULL_DUTY = (CNT_WIDTH+1)'(PERIOD_TICKS);
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         after_end_r <= 1'b0;
      end else begin
         after_end_r <= tk.period_end;
      end
   end

   sequence loaded_s;
      boundary_s ##1 duty_r != DUTY_RESET;
   endsequence

   sequence zero_word_s;
      tk.period_end && i_control_output_word == 12'h000;
   endsequence

   sequence full_word_s;
      tk.period_end && i_control_output_word == 12'hfff;
   endsequence

   reset_off_a: assert property (@(posedge i_clock)
      i_rst |=> !o_on_off_output && duty_r == DUTY_RESET)
      else $error("outputs not cleared by reset");

   tick_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
      tk.tick |=> !tk.tick)
      else $error("tick longer than one cycle");

   end_on_tick_a: assert property (@(posedge i_clock) disable iff (i_rst)
      tk.period_end |-> tk.tick)
      else $error("period end away from a tick");

   timer_cap_a: assert property (@(posedge i_clock) disable iff (i_rst)
      duty_timer_r <= duty_r)
      else $error("duty timer passed its preset");

   timer_inc_a: assert property (@(posedge i_clock) disable iff (i_rst)
      tk.tick && !tk.period_end && duty_timer_r < duty_r
      |=> duty_timer_r == $past(duty_timer_r) + (CNT_WIDTH+1)'(1))
      else $error("duty timer missed a tick");

   done_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      duty_timer_r >= duty_r && !tk.period_end |=> $stable(duty_timer_r))
      else $error("duty timer moved after expiry");

   zero_duty_a: assert property (@(posedge i_clock) disable iff (i_rst)
      duty_r == DUTY_RESET |=> !o_on_off_output)
      else $error("output on with zero duty");

   full_duty_a: assert property (@(posedge i_clock) disable iff (i_rst)
      duty_r == FULL_DUTY && !tk.period_end |=> o_on_off_output)
      else $error("output off with full duty");

   load_on_a: assert property (@(posedge i_clock) disable iff (i_rst)
      loaded_s |=> o_on_off_output)
      else $error("output not on at period start");

   fall_cause_a: assert property (@(posedge i_clock) disable iff (i_rst)
      $fell(o_on_off_output) |-> $past(duty_done || tk.period_end))
      else $error("output dropped before expiry");

   rise_cause_a: assert property (@(posedge i_clock) disable iff (i_rst)
      $rose(o_on_off_output) |-> $past(after_end_r))
      else $error("output rose away from period start");

   start_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
      after_end_r |-> !o_on_off_output)
      else $error("output on in clearing cycle");

   change_only_a: assert property (@(posedge i_clock) disable iff (i_rst)
      $changed(duty_r) |-> $past(tk.period_end))
      else $error("duty count changed away from boundary");

   zero_scale_a: assert property (@(posedge i_clock) disable iff (i_rst)
      zero_word_s |=> duty_r == DUTY_RESET)
      else $error("zero word not scaled to zero");

   full_scale_a: assert property (@(posedge i_clock) disable iff (i_rst)
      full_word_s |=> duty_r == FULL_DUTY)
      else $error("full word not scaled to full period");
endmodule
